// >>> csv_regs.svh
// Register offsets, field positions, reset values and timing for the
// card socket video port control block.
// Assumes inclusion by csv_pkg.sv, the design module, the checker and the bench.
`ifndef CSV_REGS_SVH
`define CSV_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define CSV_OFS_PRESENT  8'h08
`define CSV_OFS_FORCE    8'h0c
`define CSV_OFS_SOCKCTL  8'h10
`define CSV_OFS_SYSCTL   8'h80
`define CSV_OFS_CARDCTL  8'h91
`define CSV_OFS_DIAG     8'h93

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CSV_BIT_VSUPPORT      27
`define CSV_BIT_ACTIVITY      11
`define CSV_BIT_STD_PRESENT   10
`define CSV_BIT_STD_EN        9
`define CSV_BIT_SW_CLK        27
`define CSV_BIT_LEGACY_EN     6
`define CSV_BIT_PORT_PRIO     5
`define CSV_BIT_STD_DISABLE   0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CSV_RST_SYSCTL   32'h0000_0000
`define CSV_RST_BYTE     8'h00
`define CSV_RST_SOCKCTL  32'h0000_0000

// ----------------------------------------------------------------------
// Timing: switch clock divider half period in bus clocks
// ----------------------------------------------------------------------
`define CSV_SW_CLK_HALF  8'h10

`endif

// >>> csv_pkg.sv
// Types shared by the card socket video port control block.
// Assumes csv_regs.svh alongside.
`default_nettype none
`include "csv_regs.svh"

package csv_pkg;

   typedef enum logic [2:0] {
      CSV_IF_NONE,
      CSV_IF_16BIT,
      CSV_IF_CARDBUS,
      CSV_IF_RESERVED
   } csv_iface_t;

   typedef enum {
      CSV_ST_EMPTY,
      CSV_ST_SETTLE,
      CSV_ST_CLASSIFY,
      CSV_ST_READY
   } csv_state_t;

endpackage : csv_pkg

`default_nettype wire

// >>> csv_socket_video.sv
// Socket-side logic: card classification, switch clock source, video
// pass-through enables, address tri-state and external driver selects.
// Assumes a register port on the bus clock; card pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "csv_regs.svh"

module csv_socket_video
   import csv_pkg::*;
#(
   parameter int SETTLE_CYCLES = 16
)(
   input  wire logic        i_ref_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic        i_reg_sock,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   output logic      [31:0] o_reg_rdata,
   input  wire logic [1:0]  i_card_detect_one,
   input  wire logic [1:0]  i_card_detect_two,
   input  wire logic [1:0]  i_voltage_sense_one,
   input  wire logic [1:0]  i_voltage_sense_two,
   input  wire logic [1:0]  i_cross_cd1_vs1,
   input  wire logic [1:0]  i_cross_cd1_vs2,
   input  wire logic [1:0]  i_cross_cd2_vs1,
   input  wire logic [1:0]  i_cross_cd2_vs2,
   input  wire logic [1:0]  i_socket_powered,
   output logic      [1:0]  o_card_ready,
   output logic      [5:0]  o_card_kind,
   output logic      [1:0]  o_supply_5v,
   output logic      [1:0]  o_supply_3v3,
   output logic      [1:0]  o_supply_low,
   input  wire logic        i_power_switch_serial_clk,
   output logic             o_power_switch_serial_clk,
   output logic             o_power_switch_serial_clk_oe,
   input  wire logic        i_power_switch_serial_data,
   input  wire logic        i_power_switch_serial_latch,
   output logic             o_power_switch_serial_data,
   output logic             o_power_switch_serial_latch,
   output logic             o_power_switch_timing_clk,
   output logic      [1:0]  o_addr_hi_oe,
   output logic      [1:0]  o_addr_lo_oe,
   output logic             o_video_select_socket0_n,
   output logic             o_video_select_socket1_n,
   output logic             o_video_active_out
);

   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255)
   begin : g_bad_settle
      $error("SETTLE_CYCLES out of range");
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [31:0] system_control;
   logic [7:0]  card_control [2];
   logic [7:0]  diagnostic;
   logic [1:0]  std_video_enable;
   logic [1:0]  video_platform_support;
   logic [1:0]  legacy_video_enable;
   logic        std_off;
   logic [1:0]  eff_en;
   logic        video_activity;
   logic        prio;
   logic        sel;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         system_control <= `CSV_RST_SYSCTL;
      else if (i_reg_wr && hit(i_reg_addr, `CSV_OFS_SYSCTL))
         system_control <= i_reg_wdata;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         card_control[0] <= `CSV_RST_BYTE;
         card_control[1] <= `CSV_RST_BYTE;
      end
      else if (i_reg_wr && hit(i_reg_addr, `CSV_OFS_CARDCTL))
         card_control[i_reg_sock] <= i_reg_wdata[7:0];
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         diagnostic <= `CSV_RST_BYTE;
      else if (i_reg_wr && hit(i_reg_addr, `CSV_OFS_DIAG))
         diagnostic <= i_reg_wdata[7:0];
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         std_video_enable <= 2'h0;
      else if (i_reg_wr && hit(i_reg_addr, `CSV_OFS_SOCKCTL))
         std_video_enable[i_reg_sock] <= i_reg_wdata[`CSV_BIT_STD_EN];
   end

   // Support bit changes only through the force event register
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         video_platform_support <= 2'h0;
      else if (i_reg_wr && hit(i_reg_addr, `CSV_OFS_FORCE))
         video_platform_support[i_reg_sock] <=
            i_reg_wdata[`CSV_BIT_VSUPPORT];
   end

   // ---------------------------------------------------------------
   // Video enables and selects
   // ---------------------------------------------------------------
   assign std_off = diagnostic[`CSV_BIT_STD_DISABLE];
   assign legacy_video_enable = {card_control[1][`CSV_BIT_LEGACY_EN],
                                 card_control[0][`CSV_BIT_LEGACY_EN]};
   assign eff_en = legacy_video_enable
                 | (std_off ? 2'h0 : std_video_enable);
   assign video_activity = |eff_en;
   assign prio = card_control[0][`CSV_BIT_PORT_PRIO];

   // Select socket 1 when it alone is on, or both on with priority set
   assign sel = eff_en[1] & (~eff_en[0] | prio);

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_video_select_socket0_n <= 1'b1;
         o_video_select_socket1_n <= 1'b1;
         o_video_active_out       <= 1'b0;
         o_addr_hi_oe             <= 2'h0;
         o_addr_lo_oe             <= 2'h0;
      end
      else
      begin
         o_video_select_socket0_n <= ~(video_activity & ~sel);
         o_video_select_socket1_n <= ~(video_activity & sel);
         o_video_active_out       <= video_activity;
         o_addr_hi_oe             <= i_socket_powered & ~eff_en;
         o_addr_lo_oe             <= i_socket_powered;
      end
   end

   // ---------------------------------------------------------------
   // Register read
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         o_reg_rdata <= 32'h0;
      else if (i_reg_rd)
      begin
         o_reg_rdata <= 32'h0;
         case (i_reg_addr)
            `CSV_OFS_PRESENT:
               o_reg_rdata[`CSV_BIT_VSUPPORT] <=
                  video_platform_support[i_reg_sock];
            `CSV_OFS_SOCKCTL:
            begin
               o_reg_rdata[`CSV_BIT_ACTIVITY]    <= video_activity;
               o_reg_rdata[`CSV_BIT_STD_PRESENT] <= ~std_off;
               o_reg_rdata[`CSV_BIT_STD_EN]      <=
                  std_video_enable[i_reg_sock];
            end
            `CSV_OFS_SYSCTL:
               o_reg_rdata <= system_control;
            `CSV_OFS_CARDCTL:
               o_reg_rdata[7:0] <= card_control[i_reg_sock];
            `CSV_OFS_DIAG:
               o_reg_rdata[7:0] <= diagnostic;
            default:
               o_reg_rdata <= 32'h0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Power switch serial clock
   // ---------------------------------------------------------------
   logic [7:0] div_cnt;
   logic       clk_gen;
   logic       sw_clk_s1;
   logic       sw_clk_s2;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         div_cnt <= 8'h0;
         clk_gen <= 1'b0;
      end
      else if (div_cnt == `CSV_SW_CLK_HALF - 8'h1)
      begin
         div_cnt <= 8'h0;
         clk_gen <= ~clk_gen;
      end
      else
         div_cnt <= div_cnt + 8'h1;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         sw_clk_s1 <= 1'b0;
         sw_clk_s2 <= 1'b0;
      end
      else
      begin
         sw_clk_s1 <= i_power_switch_serial_clk;
         sw_clk_s2 <= sw_clk_s1;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_power_switch_serial_clk    <= 1'b0;
         o_power_switch_serial_clk_oe <= 1'b0;
         o_power_switch_timing_clk    <= 1'b0;
         o_power_switch_serial_data   <= 1'b0;
         o_power_switch_serial_latch  <= 1'b0;
      end
      else
      begin
         o_power_switch_serial_clk    <= clk_gen;
         o_power_switch_serial_clk_oe <= system_control[`CSV_BIT_SW_CLK];
         o_power_switch_timing_clk    <= system_control[`CSV_BIT_SW_CLK]
                                         ? clk_gen : sw_clk_s2;
         o_power_switch_serial_data   <= i_power_switch_serial_data;
         o_power_switch_serial_latch  <= i_power_switch_serial_latch;
      end
   end

   // ---------------------------------------------------------------
   // Card interrogation, one machine per socket
   // ---------------------------------------------------------------
   for (genvar s = 0; s < 2; s++)
   begin : g_sock
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] cnt;
      csv_state_t state;
      csv_iface_t kind;
      logic       present;
      logic [2:0] sup;
      logic       rdy;
      logic [2:0] knd;
      logic [2:0] spl;

      always_ff @(posedge i_ref_clk)
      begin
         if (i_sys_rst)
         begin
            p1 <= 8'hf0;
            p2 <= 8'hf0;
         end
         else
         begin
            // Order: cd2, cd1, vs2, vs1 levels, then the four links
            p1 <= {i_card_detect_two[s], i_card_detect_one[s],
                   i_voltage_sense_two[s], i_voltage_sense_one[s],
                   i_cross_cd1_vs1[s], i_cross_cd1_vs2[s],
                   i_cross_cd2_vs1[s], i_cross_cd2_vs2[s]};
            p2 <= p1;
         end
      end

      // Both detects grounded means a card sits in the socket
      assign present = ~p2[7] & ~p2[6];

      // 16-bit cards ground both detects; links mark bus cards
      always_comb
      begin
         kind = CSV_IF_16BIT;
         sup  = 3'h0;
         if (p2[3] && p2[5])
         begin
            kind = CSV_IF_CARDBUS;
            sup  = 3'b010;
         end
         else if (p2[3] || (p2[2] && !p2[4]))
            kind = CSV_IF_RESERVED;
         else if (p2[2])
         begin
            kind = CSV_IF_CARDBUS;
            sup  = 3'b011;
         end
         else if (p2[1] || p2[0])
         begin
            kind = CSV_IF_CARDBUS;
            sup  = {1'b0, ~(p2[0] ? p2[4] : p2[5]), 1'b1};
         end
         else
            case (p2[5:4])
               2'b11: sup = 3'b100;
               2'b10: sup = 3'b110;
               2'b00: sup = 3'b111;
               default: sup = 3'b001;
            endcase
      end

      always_ff @(posedge i_ref_clk)
      begin
         if (i_sys_rst)
         begin
            state <= CSV_ST_EMPTY;
            cnt   <= 8'h0;
            rdy   <= 1'b0;
            knd   <= CSV_IF_NONE;
            spl   <= 3'h0;
         end
         else
            case (state)
               CSV_ST_EMPTY:
                  if (present && !i_socket_powered[s])
                  begin
                     cnt   <= 8'h0;
                     state <= CSV_ST_SETTLE;
                  end
               CSV_ST_SETTLE:
                  if (!present)
                     state <= CSV_ST_EMPTY;
                  else if (cnt == 8'(SETTLE_CYCLES - 1))
                     state <= CSV_ST_CLASSIFY;
                  else
                     cnt <= cnt + 8'h1;
               CSV_ST_CLASSIFY:
               begin
                  knd   <= kind;
                  spl   <= sup;
                  rdy   <= 1'b1;
                  state <= CSV_ST_READY;
               end
               CSV_ST_READY:
                  if (!present)
                  begin
                     rdy   <= 1'b0;
                     knd   <= CSV_IF_NONE;
                     spl   <= 3'h0;
                     state <= CSV_ST_EMPTY;
                  end
               default:
                  state <= CSV_ST_EMPTY;
            endcase
      end
   end

   assign o_card_ready = {g_sock[1].rdy, g_sock[0].rdy};
   assign o_card_kind  = {g_sock[1].knd, g_sock[0].knd};
   assign o_supply_5v  = {g_sock[1].spl[2], g_sock[0].spl[2]};
   assign o_supply_3v3 = {g_sock[1].spl[1], g_sock[0].spl[1]};
   assign o_supply_low = {g_sock[1].spl[0], g_sock[0].spl[0]};

endmodule : csv_socket_video

`default_nettype wire

// >>> csv_socket_video_asserts.sv
// Concurrent checks on the ports of the socket video block.
// Assumes the design top csv_socket_video and its register header.
`timescale 1ns/1ps
`default_nettype none
`include "csv_regs.svh"

module csv_socket_video_asserts (
   input wire logic        i_ref_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic [7:0]  i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic [31:0] o_reg_rdata,
   input wire logic [1:0]  i_socket_powered,
   input wire logic [1:0]  o_card_ready,
   input wire logic        o_power_switch_serial_clk,
   input wire logic        o_power_switch_serial_clk_oe,
   input wire logic        o_power_switch_timing_clk,
   input wire logic [1:0]  o_addr_hi_oe,
   input wire logic [1:0]  o_addr_lo_oe,
   input wire logic        o_video_select_socket0_n,
   input wire logic        o_video_select_socket1_n,
   input wire logic        o_video_active_out
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);

   AST_COLD_CLASSIFY: assert property (
      $rose(o_card_ready[0]) |-> !i_socket_powered[0])
      else $error("card classified in a powered socket");
   AST_CLK_INPUT: assert property ($fell(i_sys_rst)
      |-> !o_power_switch_serial_clk_oe)
      else $error("switch clock driven after reset");
   AST_CLK_DRIVE: assert property (
      i_reg_wr && i_reg_addr == `CSV_OFS_SYSCTL && i_reg_wdata[27]
      |-> ##[1:2] o_power_switch_serial_clk_oe)
      else $error("switch clock not driven");
   AST_CLK_RUNS: assert property ($rose(o_power_switch_serial_clk_oe)
      |-> ##[1:40] $changed(o_power_switch_serial_clk))
      else $error("generated switch clock idle");
   AST_TIMING_SRC: assert property (
      o_power_switch_serial_clk_oe
      |-> o_power_switch_timing_clk == o_power_switch_serial_clk)
      else $error("timing clock is not the generated clock");
   AST_LEGACY_ON: assert property (
      i_reg_wr && i_reg_addr == `CSV_OFS_CARDCTL && i_reg_wdata[6]
      |-> ##2 o_video_active_out)
      else $error("legacy enable gave no video");
   AST_HI_TRISTATE: assert property (
      (o_video_select_socket0_n || !o_addr_hi_oe[0])
      && (o_video_select_socket1_n || !o_addr_hi_oe[1]))
      else $error("upper address driven during video");
   AST_LO_DRIVEN: assert property (
      i_socket_powered == $past(i_socket_powered)
      && i_socket_powered == $past(i_socket_powered, 2)
      |-> o_addr_lo_oe == i_socket_powered)
      else $error("low address enable wrong");
   AST_SEL_ONE: assert property (
      o_video_select_socket0_n || o_video_select_socket1_n)
      else $error("both socket selects low");
   AST_STAT_SEL: assert property (o_video_active_out ==
      (!o_video_select_socket0_n || !o_video_select_socket1_n))
      else $error("video status disagrees with selects");
   AST_ACT_BIT: assert property (
      i_reg_rd && i_reg_addr == `CSV_OFS_SOCKCTL
      |=> o_reg_rdata[11] == o_video_active_out)
      else $error("activity bit disagrees with status");
endmodule : csv_socket_video_asserts

bind csv_socket_video csv_socket_video_asserts u_asserts (
   .i_ref_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
   .i_reg_wdata, .o_reg_rdata, .i_socket_powered, .o_card_ready,
   .o_power_switch_serial_clk, .o_power_switch_serial_clk_oe,
   .o_power_switch_timing_clk,
   .o_addr_hi_oe, .o_addr_lo_oe, .o_video_select_socket0_n,
   .o_video_select_socket1_n, .o_video_active_out);
`default_nettype wire

// >>> csv_card_model.sv
// Far side model: cards in both sockets and the switch clock source.
// Assumes the bench muxes the clock pin with the design's enable.
`timescale 1ns/1ps
`default_nettype none

module csv_card_model (
   input  wire logic       i_ref_clk,
   input  wire logic [3:0] i_kind,
   input  wire logic       i_clk_drive,
   output logic      [1:0] o_cd1,
   output logic      [1:0] o_cd2,
   output logic      [1:0] o_vs1,
   output logic      [1:0] o_vs2,
   output logic      [1:0] o_x11,
   output logic            o_sw_clk
);
   // ---------------------------------------------------------------
   // Card terminals, two bits of kind per socket
   // ---------------------------------------------------------------
   logic [3:0] cnt = 4'h0;

   always_comb
   begin
      for (int s = 0; s < 2; s++)
      begin
         case (i_kind[2*s +: 2])
            2'd0: {o_cd2[s], o_cd1[s], o_vs2[s], o_vs1[s], o_x11[s]} = 5'h1e;
            2'd1: {o_cd2[s], o_cd1[s], o_vs2[s], o_vs1[s], o_x11[s]} = 5'h06;
            2'd2: {o_cd2[s], o_cd1[s], o_vs2[s], o_vs1[s], o_x11[s]} = 5'h05;
            default:
               {o_cd2[s], o_cd1[s], o_vs2[s], o_vs1[s], o_x11[s]} = 5'h01;
         endcase
      end
   end

   // Free-running switch clock, held low while the design drives
   always @(posedge i_ref_clk)
   begin
      cnt <= cnt + 4'h1;
   end
   assign o_sw_clk = cnt[3] & ~i_clk_drive;
endmodule : csv_card_model
`default_nettype wire

// >>> card_socket_video_port_control_tb.sv
// Self-checking bench for the socket video block.
// Assumes design, package, card model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "csv_regs.svh"

module card_socket_video_port_control_tb;
   import csv_pkg::*;
   // ---------------------------------------------------------------
   // Signals, scoreboard and tasks
   // ---------------------------------------------------------------
   typedef struct packed {logic [31:0] d, m; logic [5:0] v;} csv_note_t;
   logic        i_ref_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        i_reg_wr = 1'b0;
   logic        i_reg_rd = 1'b0;
   logic        i_reg_sock = 1'b0;
   logic [7:0]  i_reg_addr = 8'h00;
   logic [31:0] i_reg_wdata = 32'h0;
   logic [1:0]  i_socket_powered = 2'b00;
   logic        i_power_switch_serial_data = 1'b0;
   logic        i_power_switch_serial_latch = 1'b0;
   logic [3:0]  kind = 4'h0;
   logic [1:0]  leg, stdv;
   logic        dis, prio, drv;
   logic        rd_q = 1'b0;
   logic [31:0] lfsr = 32'hfb28;
   csv_note_t   q[$];
   csv_note_t   n;
   int          n_errors = 0;
   int          comparisons = 0;
   wire logic [1:0] i_card_detect_one, i_card_detect_two, x11;
   wire logic [1:0] i_voltage_sense_one, i_voltage_sense_two;
   wire logic   m_clk;
   wire logic   i_power_switch_serial_clk;
   logic [31:0] o_reg_rdata;
   logic [5:0]  o_card_kind;
   logic [1:0]  o_card_ready, o_supply_5v, o_supply_3v3, o_supply_low;
   logic [1:0]  o_addr_hi_oe, o_addr_lo_oe;
   logic        o_power_switch_serial_clk, o_power_switch_serial_clk_oe;
   logic        o_power_switch_serial_data, o_power_switch_serial_latch;
   logic        o_video_select_socket0_n, o_video_select_socket1_n;
   logic        o_video_active_out;

   assign i_power_switch_serial_clk = o_power_switch_serial_clk_oe ?
                                      o_power_switch_serial_clk : m_clk;

   csv_socket_video #(.SETTLE_CYCLES(2)) uut (
      .i_ref_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_sock,
      .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_card_detect_one,
      .i_card_detect_two, .i_voltage_sense_one, .i_voltage_sense_two,
      .i_cross_cd1_vs1(x11), .i_cross_cd1_vs2(2'b00),
      .i_cross_cd2_vs1(2'b00), .i_cross_cd2_vs2(2'b00),
      .i_socket_powered, .o_card_ready, .o_card_kind, .o_supply_5v,
      .o_supply_3v3, .o_supply_low, .i_power_switch_serial_clk,
      .o_power_switch_serial_clk, .o_power_switch_serial_clk_oe,
      .i_power_switch_serial_data, .i_power_switch_serial_latch,
      .o_power_switch_serial_data, .o_power_switch_serial_latch,
      .o_power_switch_timing_clk(), .o_addr_hi_oe, .o_addr_lo_oe,
      .o_video_select_socket0_n, .o_video_select_socket1_n,
      .o_video_active_out);

   csv_card_model u_card (
      .i_ref_clk, .i_kind(kind), .i_clk_drive(o_power_switch_serial_clk_oe),
      .o_cd1(i_card_detect_one), .o_cd2(i_card_detect_two),
      .o_vs1(i_voltage_sense_one), .o_vs2(i_voltage_sense_two),
      .o_x11(x11), .o_sw_clk(m_clk));

   function automatic logic [4:0] vid();
      logic [1:0] e;
      logic       s1;
      e = leg | (stdv & {2{~dis}});
      s1 = e[1] & (prio | ~e[0]);
      return {~(e[0] & ~s1), ~s1, |e, i_socket_powered & ~e};
   endfunction : vid

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   task automatic do_reset();
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      {leg, stdv, dis, prio, drv} = '0;
   endtask : do_reset

   task automatic wr_reg(input logic s, input logic [7:0] a,
                         input logic [31:0] d);
      @(posedge i_ref_clk);
      i_reg_wr <= 1'b1;
      i_reg_sock <= s;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_ref_clk);
      i_reg_wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic s, input logic [7:0] a,
                         input logic [31:0] e, input logic [31:0] m);
      q.push_back({e & m, m, vid(), drv});
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b1;
      i_reg_sock <= s;
      i_reg_addr <= a;
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b0;
   endtask : rd_reg

   task automatic rd_ctl(input logic s);
      logic [1:0] e;
      e = leg | (stdv & {2{~dis}});
      rd_reg(s, `CSV_OFS_SOCKCTL, {20'h0, |e, ~dis, stdv[s], 9'h0},
             32'h0e00);
   endtask : rd_ctl

   task automatic wait_ready();
      int t = 0;
      while (o_card_ready[0] !== 1'b1 && t < 200)
      begin
         @(posedge i_ref_clk);
         t++;
      end
      if (t == 200)
      begin
         n_errors++;
         summarize();
      end
   endtask : wait_ready

   // ---------------------------------------------------------------
   // Clock, monitor, watchdog and main sequence
   // ---------------------------------------------------------------
   initial
   begin
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end

   always @(posedge i_ref_clk)
   begin
      if (rd_q)
      begin
         n = q.pop_front();
         check(o_reg_rdata & n.m, n.d);
         check({26'h0, o_video_select_socket0_n, o_video_select_socket1_n,
                o_video_active_out, o_addr_hi_oe,
                o_power_switch_serial_clk_oe},
               {26'h0, n.v});
         check({30'h0, o_addr_lo_oe}, {30'h0, i_socket_powered});
      end
      rd_q <= i_reg_rd;
   end

   initial
   begin
      repeat (20000) @(posedge i_ref_clk);
      n_errors++;
      summarize();
   end

   initial
   begin
      do_reset();
      rd_reg(0, `CSV_OFS_SYSCTL, 32'h0, 32'h0800_0000);
      rd_reg(0, 8'h44, 32'h0, 32'hffff_ffff);
      for (int k = 1; k < 4; k++)
      begin
         @(posedge i_ref_clk);
         kind <= 4'(k);
         do_reset();
         wait_ready();
         check({29'h0, o_card_kind[2:0]}, 32'(k));
         if (k < 3)
            check({29'h0, o_supply_5v[0], o_supply_3v3[0], o_supply_low[0]},
                  (k == 1) ? 32'h4 : 32'h2);
         check({24'h0, o_card_kind[5:3], o_supply_5v[1], o_supply_3v3[1],
                o_supply_low[1], o_card_ready}, 32'h1);
      end
      i_socket_powered <= 2'b01;
      wr_reg(0, `CSV_OFS_SYSCTL, 32'h0800_0000);
      drv = 1'b1;
      rd_reg(0, `CSV_OFS_SYSCTL, 32'h0800_0000, 32'h0800_0000);
      repeat (40) @(posedge i_ref_clk);
      for (int s = 0; s < 2; s++)
      begin
         wr_reg(1'(s), `CSV_OFS_FORCE, 32'h0800_0000);
         wr_reg(1'(s), `CSV_OFS_PRESENT, 32'h0);
         rd_reg(1'(s), `CSV_OFS_PRESENT, 32'h0800_0000, 32'h0800_0000);
      end
      wr_reg(1, `CSV_OFS_FORCE, 32'h0);
      rd_reg(1, `CSV_OFS_PRESENT, 32'h0, 32'h0800_0000);
      wr_reg(1, `CSV_OFS_FORCE, 32'h0800_0000);
      for (int i = 0; i < 32; i++)
      begin
         lfsr = lfsr_next(lfsr);
         {dis, prio, stdv, leg} = {lfsr[9], i[4:0]};
         wr_reg(0, `CSV_OFS_CARDCTL, {25'h0, leg[0], prio, 5'h0});
         wr_reg(1, `CSV_OFS_CARDCTL, {25'h0, leg[1], 6'h0});
         wr_reg(0, `CSV_OFS_DIAG, {31'h0, dis});
         wr_reg(1, `CSV_OFS_DIAG, {31'h0, dis});
         wr_reg(0, `CSV_OFS_SOCKCTL, {22'h0, stdv[0], 9'h0});
         wr_reg(1, `CSV_OFS_SOCKCTL, {22'h0, stdv[1], 9'h0});
         i_power_switch_serial_data <= lfsr[3];
         i_power_switch_serial_latch <= lfsr[4];
         rd_ctl(0);
         rd_ctl(1);
         rd_reg(0, `CSV_OFS_CARDCTL, {25'h0, leg[0], prio, 5'h0}, 32'h60);
         check({30'h0, o_power_switch_serial_data,
                o_power_switch_serial_latch},
               {30'h0, lfsr[3], lfsr[4]});
      end
      repeat (4) @(posedge i_ref_clk);
      check(32'(q.size()), 32'h0);
      summarize();
   end
endmodule : card_socket_video_port_control_tb
`default_nettype wire
